// ===== include/stx_pkg.sv
// Package for the SPI transfer begin/end and status block.
// Assumes one clock domain; all users reference names as stx_pkg::name.
package stx_pkg;
	localparam int unsigned WIDTH_DEFAULT    = 32'd8;
	localparam int unsigned RATIO_DEFAULT    = 32'd16;
	localparam int unsigned NUM_SEL_DEFAULT  = 32'd1;
	localparam int unsigned FIFO_DEPTH       = 32'd4;
	localparam int unsigned SR_RX_EMPTY      = 32'd0;
	localparam int unsigned SR_RX_FULL       = 32'd1;
	localparam int unsigned SR_TX_EMPTY      = 32'd2;
	localparam int unsigned SR_TX_FULL       = 32'd3;
	localparam int unsigned SR_MODE_FAULT    = 32'd4;
	localparam int unsigned IR_MODE_FAULT    = 32'd0;
	localparam int unsigned IR_SLV_MODE_FAULT_FLAG      = 32'd1;
	localparam int unsigned IR_TX_EMPTY      = 32'd2;
	localparam int unsigned IR_UNDERRUN      = 32'd3;
	localparam int unsigned IR_RX_FULL       = 32'd4;
	localparam int unsigned IR_TX_HALF       = 32'd6;
	localparam logic [4:0]  STATUS_RESET     = 5'h05;
	localparam logic [7:0]  INTR_RESET       = 8'h00;

	typedef struct packed {
		logic master;
		logic cpol;
		logic cpha;
		logic lsb_first;
		logic enable;
		logic fifo_mode;
		logic multi_io;
		logic execute_in_place;
	} stx_cfg_t;

	typedef struct packed {
		logic sck;
		logic sel_n;
		logic mosi;
	} stx_pins_t;
endpackage

// ===== hw/stx_core.sv
// SPI transfer control: begin/end of transfers, status and interrupt flags.
// Assumes pins come from outside the domain and a single core clock.
// Summary of operation
// - Slave, phase zero: falling select edge begins a transfer.
// - Slave, phase one: first clock edge after selection begins a transfer.
// - Select released mid transfer aborts and resets shifter and bit counter.
// - Slave drives its first transmit bit on the falling select edge in phase zero, on the first clock edge in phase one.
// - Slave transfer start with no transmit data raises underrun interrupt.
// - Without FIFOs, receive-full status bit 1 marks each transfer end.
// - Received data available raises interrupt status bit 4.
// - Receive register captures word on same edge receive-full interrupt rises.
// - Master end clears receive-empty bit 0, transmit-full and status bit 3.
// - Master end sets receive-full status bit 1, and transmit-empty bit 2 when no transmit word is queued.
// - Receive-full, slave mode-fault and interrupt bit 1 set after last cycle.
// - Phase one end edge is supplied by the internal clock counter.
// - One counter makes status and interrupt bits update in the same cycle.
// - With FIFOs, flags report only the first and last of a burst.
// - Transmit FIFO half empty raises interrupt status bit 6.
// - Slave end-of-transfer flag updates match master timing in phase one; phase zero waits for a clock edge.
// - Width is 8, 16 or 32; fixed 8 in multi-line and execute-in-place.
// - Serial clock is reference divided by power-of-two ratio 2 to 2048.
// - Multi-line and execute-in-place force divide ratio 2.
// - Select count 1 to 32, fixed at one in execute-in-place.

////////////////////////////////////////////////////////////////////////////////

module stx_fifo #(
	parameter int unsigned WIDTH = 32'd8,
	parameter int unsigned DEPTH = 32'd4
) (
	input  wire logic             core_clk_in,
	input  wire logic             arst_n_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out,
	output logic [$clog2(DEPTH):0] count_out
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0]      count, next_count;
	logic             push, pop;

	always_comb begin
		push = in_valid_in && in_ready_out;
		pop = out_valid_out && out_ready_in;
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count = (AW+1)'(count + {AW'(0), push} - {AW'(0), pop});
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage has no reset so it maps to distributed memory.
	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	assign in_ready_out = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];
	assign count_out = count;
endmodule

////////////////////////////////////////////////////////////////////////////////

module stx_core #(
	parameter int unsigned WIDTH   = stx_pkg::WIDTH_DEFAULT,
	parameter int unsigned RATIO   = stx_pkg::RATIO_DEFAULT,
	parameter int unsigned NUM_SEL = stx_pkg::NUM_SEL_DEFAULT
) (
	input  wire logic                 core_clk_in,
	input  wire logic                 arst_n_in,
	input  wire stx_pkg::stx_cfg_t    cfg_in,
	input  wire logic [NUM_SEL-1:0]   sel_reg_in,
	input  wire logic                 tx_valid_in,
	output logic                      tx_ready_out,
	input  wire logic [WIDTH-1:0]     tx_data_in,
	output logic                      rx_valid_out,
	input  wire logic                 rx_ready_in,
	output logic      [WIDTH-1:0]     rx_data_out,
	output logic      [2:0]           tx_level_out,
	output logic      [WIDTH-1:0]     receive_data_reg_out,
	output logic      [4:0]           serial_status_reg_out,
	output logic      [7:0]           intr_status_reg_out,
	input  wire logic [7:0]           intr_clear_in,
	output logic                      transfer_done_flag_out,
	input  wire stx_pkg::stx_pins_t   pins_in,
	output logic                      sck_out,
	output logic                      sck_oe_out,
	output logic                      mosi_out,
	output logic                      mosi_oe_out,
	output logic                      miso_out,
	output logic                      miso_oe_out,
	input  wire logic                 miso_in,
	output logic      [NUM_SEL-1:0]   sel_n_out
);
	typedef enum logic [3:0] {
		STX_IDLE  = 4'h1,
		STX_SHIFT = 4'h2,
		STX_END   = 4'h4,
		STX_DONE  = 4'h8
	} stx_state_t;

	function automatic logic [5:0] eff_bits(input stx_pkg::stx_cfg_t c);
		eff_bits = (c.multi_io || c.execute_in_place) ? 6'd8 : 6'(WIDTH);
	endfunction

	function automatic logic [11:0] eff_half(input stx_pkg::stx_cfg_t c);
		eff_half = (c.multi_io || c.execute_in_place) ? 12'd1 : 12'(RATIO / 2);
	endfunction

	stx_state_t       state, next_state;
	logic [2:0]       sck_s1, sck_s2, sck_s3;
	logic             sck_sync, sel_sync, mosi_sync, sck_prev, sel_prev;
	logic             miso_s1, miso_s2;
	logic [11:0]      div, next_div;
	logic [5:0]       bitcnt, next_bitcnt;
	logic             phase, next_phase;
	logic             sck_int, next_sck_int;
	logic [WIDTH-1:0] shreg, next_shreg;
	logic [WIDTH-1:0] rdr, next_rdr;
	logic [4:0]       sr, next_sr;
	logic [7:0]       isr, next_isr;
	logic             burst, next_burst;
	logic             tx_half_prev;
	logic             f_valid, f_pop, rx_push, rx_in_ready;
	logic [WIDTH-1:0] f_data;
	logic [2:0]       f_count;
	logic             sel_fall, sel_rise, sck_edge, start, abort, end_evt, slave;
	logic             sample_bit, din;
	logic [5:0]       nbits;
	logic             out_q, next_out_q;

	stx_fifo #(.WIDTH(WIDTH), .DEPTH(stx_pkg::FIFO_DEPTH)) u_tx_fifo (
		.core_clk_in  (core_clk_in),
		.arst_n_in    (arst_n_in),
		.in_valid_in  (tx_valid_in),
		.in_ready_out (tx_ready_out),
		.in_data_in   (tx_data_in),
		.out_valid_out(f_valid),
		.out_ready_in (f_pop),
		.out_data_out (f_data),
		.count_out    (f_count)
	);

	stx_fifo #(.WIDTH(WIDTH), .DEPTH(stx_pkg::FIFO_DEPTH)) u_rx_fifo (
		.core_clk_in  (core_clk_in),
		.arst_n_in    (arst_n_in),
		.in_valid_in  (rx_push),
		.in_ready_out (rx_in_ready),
		.in_data_in   (next_rdr),
		.out_valid_out(rx_valid_out),
		.out_ready_in (rx_ready_in),
		.out_data_out (rx_data_out),
		.count_out    ()
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pin inputs pass two flops; edge detection reads only the second stage onward.

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sck_s1 <= 3'h2;
			sck_s2 <= 3'h2;
			sck_s3 <= 3'h2;
			miso_s1 <= 1'b0;
			miso_s2 <= 1'b0;
			tx_half_prev <= 1'b1;
		end else begin
			sck_s1 <= {pins_in.sck, pins_in.sel_n, pins_in.mosi};
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			miso_s1 <= miso_in;
			miso_s2 <= miso_s1;
			tx_half_prev <= (f_count <= 3'(stx_pkg::FIFO_DEPTH / 2));
		end
	end

	always_comb begin
		sck_sync = sck_s2[2];
		sel_sync = sck_s2[1];
		mosi_sync = sck_s2[0];
		sck_prev = sck_s3[2];
		sel_prev = sck_s3[1];
	end

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		slave = !cfg_in.master;
		nbits = eff_bits(cfg_in);
		sel_fall = slave && sel_prev && !sel_sync;
		sel_rise = slave && !sel_prev && sel_sync;
		sck_edge = slave && (sck_prev != sck_sync) && !sel_sync;
		abort = (state == STX_SHIFT) && (slave ? sel_rise : !cfg_in.enable);
		start = 1'b0;
		if (state == STX_IDLE) begin
			if (slave) begin
				start = cfg_in.cpha ? (sck_edge && !sel_fall) : sel_fall;
			end else begin
				start = cfg_in.enable && f_valid;
			end
		end
		next_state = state;
		next_div = div;
		next_bitcnt = bitcnt;
		next_phase = phase;
		next_sck_int = sck_int;
		next_shreg = shreg;
		next_rdr = rdr;
		next_burst = burst;
		next_out_q = out_q;
		end_evt = 1'b0;
		f_pop = 1'b0;
		sample_bit = 1'b0;
		din = slave ? mosi_sync : miso_s2;
		unique case (state)
			STX_IDLE: begin
				next_sck_int = cfg_in.cpol;
				next_div = '0;
				next_bitcnt = '0;
				next_phase = 1'b0;
				if (start) begin
					next_state = STX_SHIFT;
					next_shreg = f_valid ? f_data : '0;
					next_out_q = cfg_in.lsb_first ? next_shreg[0] : next_shreg[WIDTH-1];
					f_pop = f_valid;
					if (slave && cfg_in.cpha) begin
						next_phase = 1'b1;
					end
				end
			end
			STX_SHIFT: begin
				if (slave) begin
					// slave ends at the same edge count as a master.
					if (sck_edge) begin
						next_phase = !phase;
						sample_bit = (phase == cfg_in.cpha);
					end
				end else if (div == 12'(eff_half(cfg_in) - 1)) begin
					next_div = '0;
					next_sck_int = !sck_int;
					next_phase = !phase;
					sample_bit = (phase == cfg_in.cpha);
				end else begin
					next_div = 12'(div + 1'b1);
				end
				if (sample_bit) begin
					next_shreg = cfg_in.lsb_first ? {din, shreg[WIDTH-1:1]}
						: {shreg[WIDTH-2:0], din};
					next_bitcnt = 6'(bitcnt + 1'b1);
					if (6'(bitcnt + 1'b1) == nbits) begin
						next_state = STX_END;
						next_div = '0;
					end
				end
				if (next_phase != phase && !sample_bit) begin
					next_out_q = cfg_in.lsb_first ? shreg[0] : shreg[WIDTH-1];
				end
				if (abort) begin
					next_state = STX_IDLE;
					next_bitcnt = '0;
					next_shreg = '0;
				end
			end
			STX_END: begin
				// the half-period counter supplies the closing edge, except a phase-zero slave waits for a clock edge.
				if (slave && !cfg_in.cpha ? sck_edge : div == 12'(eff_half(cfg_in) - 1)) begin
					next_state = STX_DONE;
				end else begin
					next_div = 12'(div + 1'b1);
				end
				if (abort || (slave && sel_rise)) begin
					next_state = STX_IDLE;
					next_bitcnt = '0;
				end
			end
			STX_DONE: begin
				end_evt = 1'b1;
				next_rdr = cfg_in.lsb_first ? shreg : shreg;
				next_sck_int = cfg_in.cpol;
				next_state = STX_IDLE;
				next_burst = cfg_in.fifo_mode && f_valid;
			end
		endcase
	end

	assign rx_push = end_evt && rx_in_ready;

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= STX_IDLE;
			div <= '0;
			bitcnt <= '0;
			phase <= 1'b0;
			sck_int <= 1'b0;
			shreg <= '0;
			rdr <= '0;
			burst <= 1'b0;
			out_q <= 1'b0;
		end else begin
			state <= next_state;
			div <= next_div;
			bitcnt <= next_bitcnt;
			phase <= next_phase;
			sck_int <= next_sck_int;
			shreg <= next_shreg;
			rdr <= next_rdr;
			burst <= next_burst;
			out_q <= next_out_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags set and clear together on the end event; a set beats a same-cycle clear.

	always_comb begin
		logic report;
		report = end_evt && !(cfg_in.fifo_mode && burst && f_valid);
		next_sr = sr;
		next_isr = isr & ~intr_clear_in;
		if (report) begin
			next_sr[stx_pkg::SR_RX_EMPTY] = 1'b0;
			next_sr[stx_pkg::SR_TX_FULL] = 1'b0;
			next_sr[stx_pkg::SR_TX_EMPTY] = 1'b1;
			next_sr[stx_pkg::SR_RX_FULL] = 1'b1;
			next_isr[stx_pkg::IR_RX_FULL] = 1'b1;
			next_isr[stx_pkg::IR_SLV_MODE_FAULT_FLAG] = slave && sel_sync;
			next_isr[stx_pkg::IR_TX_EMPTY] = !f_valid;
		end
		if (start && slave && !f_valid) begin
			next_isr[stx_pkg::IR_UNDERRUN] = 1'b1;
		end
		if (cfg_in.fifo_mode && !tx_half_prev && (f_count <= 3'(stx_pkg::FIFO_DEPTH / 2))) begin
			next_isr[stx_pkg::IR_TX_HALF] = 1'b1;
		end
		if (rx_valid_out && rx_ready_in) begin
			next_sr[stx_pkg::SR_RX_FULL] = report;
			next_sr[stx_pkg::SR_RX_EMPTY] = !report;
		end
		if (f_valid) begin
			next_sr[stx_pkg::SR_TX_EMPTY] = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sr <= stx_pkg::STATUS_RESET;
			isr <= stx_pkg::INTR_RESET;
		end else begin
			sr <= next_sr;
			isr <= next_isr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		sck_out = sck_int;
		sck_oe_out = cfg_in.master;
		mosi_out = out_q;
		mosi_oe_out = cfg_in.master && cfg_in.enable;
		miso_out = out_q;
		miso_oe_out = slave && !sel_sync;
		sel_n_out = '1;
		if (cfg_in.master && state != STX_IDLE) begin
			sel_n_out = sel_reg_in;
		end
		if (cfg_in.execute_in_place) begin
			for (int i = 1; i < NUM_SEL; i++) sel_n_out[i] = 1'b1;
		end
	end

	assign tx_level_out = f_count;
	assign receive_data_reg_out = rdr;
	assign serial_status_reg_out = sr;
	assign intr_status_reg_out = isr;
	assign transfer_done_flag_out = sr[stx_pkg::SR_RX_FULL];
endmodule

// ===== testbench/stx_slave_model.sv
// Behavioural serial slave that faces the block when it acts as master.
// Assumes clock phase zero, idle-low clock and most significant bit first.
module stx_slave_model #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             core_clk_in,
	input  wire logic             sck_in,
	input  wire logic             sel_n_in,
	input  wire logic             mosi_in,
	input  wire logic [WIDTH-1:0] reply_in,
	output logic                  miso_out = 1'b0,
	output logic      [WIDTH-1:0] got_out = '0
);
	logic             sck_q = 1'b0;
	logic             sel_q = 1'b1;
	logic [WIDTH-1:0] sh    = '0;

	// Edges are found on the core clock, so this slave shares that clock.
	always @(posedge core_clk_in) begin
		sck_q <= sck_in;
		sel_q <= sel_n_in;
		if (sel_q && !sel_n_in) begin
			sh       <= reply_in;
			miso_out <= reply_in[WIDTH-1];
		end else if (sel_n_in) begin
			// A released line must not look like held data.
			miso_out <= ~miso_out;
		end else if (!sck_q && sck_in) begin
			got_out <= {got_out[WIDTH-2:0], mosi_in};
		end else if (sck_q && !sck_in) begin
			sh       <= sh << 1;
			miso_out <= sh[WIDTH-2];
		end
	end
endmodule

// ===== testbench/stx_core_monitor.sv
// Concurrent checks on the ports of the transfer control block.
// Checks master and slave traffic; assumes a divide ratio of 8 and one select line.
module stx_core_monitor #(
	parameter int unsigned WIDTH   = 8,
	parameter int unsigned RATIO   = 8,
	parameter int unsigned NUM_SEL = 1
) (
	input wire logic               core_clk_in,
	input wire logic               arst_n_in,
	input wire stx_pkg::stx_cfg_t  cfg_in,
	input wire stx_pkg::stx_pins_t pins_in,
	input wire logic [NUM_SEL-1:0] sel_n_out,
	input wire logic               sck_out,
	input wire logic [2:0]         tx_level_out,
	input wire logic [WIDTH-1:0]   receive_data_reg_out,
	input wire logic [4:0]         serial_status_reg_out,
	input wire logic [7:0]         intr_status_reg_out,
	input wire logic [7:0]         intr_clear_in,
	input wire logic               transfer_done_flag_out,
	input wire logic               rx_valid_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);

	chk_flags_together: assert property ($rose(intr_status_reg_out[4]) && !cfg_in.fifo_mode
		|-> serial_status_reg_out[1]) else $error("Interrupt and status bits out of step.");
	chk_rdr_capture: assert property ($changed(receive_data_reg_out)
		|-> intr_status_reg_out[4]) else $error("Receive word moved without interrupt.");
	chk_done_alias: assert property (transfer_done_flag_out == serial_status_reg_out[1])
		else $error("Done flag differs from status bit.");
	chk_end_status: assert property ($rose(serial_status_reg_out[1]) && !cfg_in.fifo_mode
		|-> !serial_status_reg_out[0] && !serial_status_reg_out[3])
		else $error("End of transfer left empty or full bit set.");
	chk_sck_idle: assert property (&sel_n_out && cfg_in.master |-> sck_out == cfg_in.cpol)
		else $error("Serial clock not idle while deselected.");
	chk_sck_period: assert property ($changed(sck_out) && cfg_in.master
		|=> $stable(sck_out) [*3]) else $error("Serial clock half period too short.");
	chk_underrun_raise: assert property ($fell(pins_in.sel_n) && !cfg_in.master
		&& cfg_in.enable && tx_level_out == 3'h0 |-> ##[1:8] intr_status_reg_out[3])
		else $error("Underrun not raised.");
	chk_tx_half: assert property ($past(tx_level_out) == 3'h3 && tx_level_out == 3'h2
		&& intr_clear_in == 8'h00 |-> ##[0:1] intr_status_reg_out[6])
		else $error("Half empty interrupt missing.");
	chk_rx_avail: assert property ($rose(intr_status_reg_out[4]) |-> ##[0:1] rx_valid_out)
		else $error("Receive interrupt without data.");

	cov_master_end: cover property ($rose(intr_status_reg_out[4]) && cfg_in.master);
	cov_underrun: cover property ($rose(intr_status_reg_out[3]));
	cov_tx_half: cover property ($rose(intr_status_reg_out[6]));
endmodule

bind stx_core stx_core_monitor #(.WIDTH(WIDTH), .RATIO(RATIO), .NUM_SEL(NUM_SEL)) u_mon (
	.core_clk_in, .arst_n_in, .cfg_in, .pins_in, .sel_n_out, .sck_out, .tx_level_out,
	.receive_data_reg_out, .serial_status_reg_out, .intr_status_reg_out, .intr_clear_in,
	.transfer_done_flag_out, .rx_valid_out
);

// ===== testbench/test_stx_core.sv
// Self-checking bench: master rows, a burst, then slave underrun, abort and words.
// Assumes 8-bit words, divide ratio 8 and one select line.
module test_stx_core;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [7:0] tx; logic [7:0] reply;} stx_row_t;
	stx_row_t rows [4] = '{'{8'hA5, 8'h3C}, '{8'h00, 8'hFF}, '{8'hFF, 8'h00}, '{8'h81, 8'h7E}};
	logic               core_clk = 1'b0;
	logic               arst_n = 1'b0;
	stx_pkg::stx_cfg_t  cfg = '0;
	stx_pkg::stx_pins_t pins = 3'b010;
	logic               tx_valid = 1'b0;
	logic               rx_ready = 1'b0;
	logic [7:0]         tx_data = 8'h00;
	logic [7:0]         intr_clear = 8'h00;
	logic [7:0]         reply = 8'h00;
	logic               tx_ready, rx_valid, done, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, miso_m;
	logic [7:0]         rx_data, rdr, intr, got;
	logic [4:0]         stat;
	logic [2:0]         tx_level;
	logic [0:0]         sel_n;
	int                 n_mismatch = 0;
	int                 n_tests = 0;
	int                 cycles = 0;
	int                 n;

	always #20 core_clk = ~core_clk;

	stx_core #(.WIDTH(8), .RATIO(8), .NUM_SEL(1)) dut (
		.core_clk_in(core_clk), .arst_n_in(arst_n), .cfg_in(cfg), .sel_reg_in(1'b0),
		.tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_data_in(tx_data),
		.rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .rx_data_out(rx_data),
		.tx_level_out(tx_level), .receive_data_reg_out(rdr), .serial_status_reg_out(stat),
		.intr_status_reg_out(intr), .intr_clear_in(intr_clear),
		.transfer_done_flag_out(done), .pins_in(pins), .sck_out(sck), .sck_oe_out(sck_oe),
		.mosi_out(mosi), .mosi_oe_out(mosi_oe), .miso_out(miso), .miso_oe_out(miso_oe),
		.miso_in(miso_m), .sel_n_out(sel_n)
	);

	stx_slave_model #(.WIDTH(8)) u_slave (
		.core_clk_in(core_clk), .sck_in(sck), .sel_n_in(sel_n[0]), .mosi_in(mosi),
		.reply_in(reply), .miso_out(miso_m), .got_out(got)
	);

	////////////////////////////////////////////////////////////////////////////////

	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task tick(input int k);
		repeat (k) @(posedge core_clk);
		#2;
	endtask

	// The word is held until an edge finds the FIFO ready, then one idle edge passes.
	task push(input logic [7:0] d);
		int i;
		i = 0;
		tx_data = d;
		tx_valid = 1'b1;
		do begin
			@(posedge core_clk);
			i++;
		end while (tx_ready !== 1'b1 && i < 400);
		#2 tx_valid = 1'b0;
		tick(1);
	endtask

	task wait_intr(input int b);
		for (int i = 0; i < 400 && intr[b] !== 1'b1; i++) tick(1);
	endtask

	task pulse_clear;
		intr_clear = 8'hFF;
		tick(1);
		intr_clear = 8'h00;
	endtask

	task pop;
		rx_ready = 1'b1;
		tick(1);
		rx_ready = 1'b0;
		tick(1);
	endtask

	task slave_word(input logic [7:0] d);
		for (int k = 7; k >= 0; k--) begin
			if (!cfg.cpha) pins.mosi = d[k];
			tick(4);
			pins.sck = 1'b1;
			if (cfg.cpha) pins.mosi = d[k];
			tick(4);
			pins.sck = 1'b0;
		end
	endtask

	task give_verdict;
		$display("Mismatches %0d in %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	initial begin
		cfg.master = 1'b1;
		cfg.enable = 1'b1;
		tick(6);
		arst_n = 1'b1;
		tick(1);
		check(8'(stat), 8'h05);
		check(intr, 8'h00);
		check(8'({sck_oe, mosi_oe, sel_n, sck}), 8'h0E);
		foreach (rows[i]) begin
			reply = rows[i].reply;
			push(rows[i].tx);
			wait_intr(4);
			tick(1);
			check(rdr, reply);
			check(rx_data, reply);
			check(8'(stat[2:0]), 8'h06);
			check(8'(stat[3]), 8'h00);
			check(8'(done), 8'h01);
			check(got, rows[i].tx);
			pop();
			pulse_clear();
		end
		// Burst with the receive side stalled: only four words can be kept.
		cfg.fifo_mode = 1'b1;
		reply = 8'h66;
		for (int k = 0; k < 6; k++) push(8'h10 + 8'(k));
		for (int i = 0; i < 2000 && (tx_level !== 3'h0 || sel_n !== 1'b1); i++) tick(1);
		tick(100);
		check(8'(intr[6]), 8'h01);
		n = 0;
		while (rx_valid === 1'b1 && n < 8) begin
			pop();
			n++;
		end
		check(8'(n), 8'h04);
		pulse_clear();
		cfg.master = 1'b0;
		cfg.fifo_mode = 1'b0;
		tick(2);
		pins.sel_n = 1'b0;
		tick(10);
		check(8'(intr[3]), 8'h01);
		pulse_clear();
		pins.sck = 1'b1;
		tick(4);
		pins.sck = 1'b0;
		tick(4);
		pins.sel_n = 1'b1;
		tick(20);
		check(8'(intr[4]), 8'h00);
		check(8'(miso_oe), 8'h00);
		for (int c = 0; c < 2; c++) begin
			cfg.cpha = c[0];
			push(8'hC3);
			pulse_clear();
			pins.sel_n = 1'b0;
			tick(4);
			if (c == 0) check(8'({miso_oe, miso}), 8'h03);
			slave_word(8'h5A ^ 8'(c));
			wait_intr(4);
			tick(1);
			check(rdr, 8'h5A ^ 8'(c));
			check(8'(intr[3]), 8'h00);
			pins.sel_n = 1'b1;
			pop();
			tick(4);
		end
		give_verdict();
	end
endmodule
